/* File: verilog/sacc_map.svh */
// Offsets, field positions, reset values and widths of the attribution checker
`ifndef SACC_MAP_SVH
`define SACC_MAP_SVH

`define SACC_DW            32
`define SACC_AW            3

`define SACC_IDX_ATTR      3'h0
`define SACC_IDX_CHK       3'h1
`define SACC_IDX_INTEN     3'h2
`define SACC_IDX_INTFLAG   3'h3
`define SACC_IDX_SEC_CFG   3'h4
`define SACC_IDX_NS_DATA   3'h5
`define SACC_IDX_MIX_PIN   3'h6
`define SACC_IDX_NVM_CTRL  3'h7

`define SACC_CHK_EN_BIT    0
`define SACC_CHK_FLAG_BIT  0
`define SACC_NVM_NSWR_BIT  31

`define SACC_RST_WORD      32'h0000_0000
`define SACC_ALL_ONES      32'hFFFF_FFFF

`endif

/* File: verilog/sacc_pkg.sv */
// Types shared by the attribution checker modules
package sacc_pkg;

  typedef enum logic [2:0] {
    SACC_CLS_NS,
    SACC_CLS_SEC,
    SACC_CLS_WSEC,
    SACC_CLS_MIX,
    SACC_CLS_WMIX
  } sacc_cls_t;

  typedef struct packed {
    logic [31:0] attr;
    logic [31:0] chk;
    logic        inten;
    logic        flag;
    logic [31:0] sec_cfg;
    logic [31:0] ns_data;
    logic [31:0] mix_pin;
    logic [31:0] nvm_ctrl;
    logic [31:0] rdata;
    logic        done;
    logic        denied;
    logic        irq;
  } sacc_state_t;

endpackage : sacc_pkg

/* File: verilog/sacc_mask.sv */
// Per-bit read and write permission for one access given register class and alias
`timescale 1ns/1ps
`include "sacc_map.svh"

module sacc_mask (
  input  sacc_pkg::sacc_cls_t      cls,
  input  wire logic                secure,
  input  wire logic [`SACC_DW-1:0] attr,
  output logic      [`SACC_DW-1:0] rd_mask,
  output logic      [`SACC_DW-1:0] wr_mask
);

  always_comb begin
    rd_mask = `SACC_ALL_ONES;
    wr_mask = `SACC_ALL_ONES;
    if (!secure) begin
      case (cls)
        sacc_pkg::SACC_CLS_NS: begin
          rd_mask = `SACC_ALL_ONES; // R6
          wr_mask = `SACC_ALL_ONES; // R6
        end
        sacc_pkg::SACC_CLS_SEC: begin
          rd_mask = `SACC_RST_WORD; // R7
          wr_mask = `SACC_RST_WORD; // R7
        end
        sacc_pkg::SACC_CLS_WSEC: begin
          rd_mask = `SACC_ALL_ONES; // R9
          wr_mask = `SACC_RST_WORD; // R9
        end
        sacc_pkg::SACC_CLS_MIX: begin
          // Each bit follows its own attribution bit
          rd_mask = attr; // R10
          wr_mask = attr; // R11
        end
        sacc_pkg::SACC_CLS_WMIX: begin
          rd_mask = `SACC_ALL_ONES; // R12
          wr_mask = attr[`SACC_NVM_NSWR_BIT] ? `SACC_ALL_ONES : `SACC_RST_WORD; // R12
        end
        default: begin
          rd_mask = `SACC_RST_WORD;
          wr_mask = `SACC_RST_WORD;
        end
      endcase
    end
  end

endmodule : sacc_mask

/* File: verilog/sacc_check.sv */
// Register bank with secure and non-secure aliases, attribution and change monitor
//
// Operation
// R1: Attribution register readable by non-secure side
// R2: Check register and flags notify security changes
// R3: Interrupt when secure changes attribution after arming
// R4: Software copies attribution to check, then enables
// R5: Handler reloads check register before returning
// R6: Non-secure registers reachable through both aliases
// R7: Secure registers never reachable through non-secure alias
// R8: Write-secure registers: secure reads and writes
// R9: Write-secure registers: non-secure reads only
// R10: Mixed registers assign resources per side
// R11: Mixed attribution enforced per bit field
// R12: Memory controller writes need non-secure authorisation
// R13: Forbidden access no effect, read returns zero
`timescale 1ns/1ps
`include "sacc_map.svh"

module sacc_check (
  input  wire logic                CLK_SYS,
  input  wire logic                RESET_N,
  input  wire logic                ACC_VALID,
  input  wire logic                ACC_SECURE,
  input  wire logic                ACC_WRITE,
  input  wire logic [`SACC_AW-1:0] ACC_IDX,
  input  wire logic [`SACC_DW-1:0] ACC_WDATA,
  output logic      [`SACC_DW-1:0] ACC_RDATA,
  output logic                     ACC_DONE,
  output logic                     ACC_DENIED,
  output logic      [`SACC_DW-1:0] ATTR_OUT,
  output logic                     CHK_IRQ
);

  sacc_pkg::sacc_state_t st_r;
  sacc_pkg::sacc_state_t st_nxt;
  sacc_pkg::sacc_cls_t   cls;
  logic [`SACC_DW-1:0]   rd_mask;
  logic [`SACC_DW-1:0]   wr_mask;
  logic [`SACC_DW-1:0]   cur;
  logic                  wr;
  logic                  attr_hit;

  function automatic sacc_pkg::sacc_cls_t class_of(input logic [`SACC_AW-1:0] idx);
    case (idx)
      `SACC_IDX_ATTR:     class_of = sacc_pkg::SACC_CLS_WSEC; // R1
      `SACC_IDX_CHK:      class_of = sacc_pkg::SACC_CLS_NS;
      `SACC_IDX_INTEN:    class_of = sacc_pkg::SACC_CLS_NS;
      `SACC_IDX_INTFLAG:  class_of = sacc_pkg::SACC_CLS_NS;
      `SACC_IDX_SEC_CFG:  class_of = sacc_pkg::SACC_CLS_SEC;
      `SACC_IDX_NS_DATA:  class_of = sacc_pkg::SACC_CLS_NS;
      `SACC_IDX_MIX_PIN:  class_of = sacc_pkg::SACC_CLS_MIX;
      `SACC_IDX_NVM_CTRL: class_of = sacc_pkg::SACC_CLS_WMIX;
      default:            class_of = sacc_pkg::SACC_CLS_SEC;
    endcase
  endfunction : class_of

  function automatic logic [`SACC_DW-1:0] merge(input logic [`SACC_DW-1:0] old_v,
                                                input logic [`SACC_DW-1:0] new_v,
                                                input logic [`SACC_DW-1:0] mask);
    merge = (old_v & ~mask) | (new_v & mask);
  endfunction : merge

  assign cls = class_of(ACC_IDX);

  sacc_mask u_mask (
    .cls     (cls),
    .secure  (ACC_SECURE),
    .attr    (st_r.attr),
    .rd_mask (rd_mask),
    .wr_mask (wr_mask)
  );

  always_comb begin
    case (ACC_IDX)
      `SACC_IDX_ATTR:     cur = st_r.attr;
      `SACC_IDX_CHK:      cur = st_r.chk;
      `SACC_IDX_INTEN:    cur = {31'h0000_0000, st_r.inten};
      `SACC_IDX_INTFLAG:  cur = {31'h0000_0000, st_r.flag};
      `SACC_IDX_SEC_CFG:  cur = st_r.sec_cfg;
      `SACC_IDX_NS_DATA:  cur = st_r.ns_data;
      `SACC_IDX_MIX_PIN:  cur = st_r.mix_pin;
      `SACC_IDX_NVM_CTRL: cur = st_r.nvm_ctrl;
      default:            cur = `SACC_RST_WORD;
    endcase
  end

  always_comb begin
    st_nxt        = st_r;
    wr            = ACC_VALID && ACC_WRITE;
    attr_hit      = 1'b0;
    st_nxt.done   = ACC_VALID;
    st_nxt.denied = 1'b0;
    st_nxt.rdata  = `SACC_RST_WORD;
    if (ACC_VALID && !ACC_WRITE) begin
      // Forbidden bits read as zero so nothing leaks across aliases
      st_nxt.rdata  = cur & rd_mask; // R13
      st_nxt.denied = (rd_mask == `SACC_RST_WORD); // R13
    end
    if (wr) begin
      st_nxt.denied = (wr_mask == `SACC_RST_WORD); // R13
      case (ACC_IDX)
        `SACC_IDX_ATTR: begin
          st_nxt.attr = merge(st_r.attr, ACC_WDATA, wr_mask); // R8
          attr_hit    = ACC_SECURE && (st_nxt.attr != st_r.chk); // R3
        end
        `SACC_IDX_CHK:      st_nxt.chk      = merge(st_r.chk, ACC_WDATA, wr_mask); // R2
        `SACC_IDX_INTEN:    st_nxt.inten    = ACC_WDATA[`SACC_CHK_EN_BIT]; // R2
        `SACC_IDX_INTFLAG: begin
          if (ACC_WDATA[`SACC_CHK_FLAG_BIT]) begin
            st_nxt.flag = 1'b0;
          end
        end
        `SACC_IDX_SEC_CFG:  st_nxt.sec_cfg  = merge(st_r.sec_cfg, ACC_WDATA, wr_mask); // R7
        `SACC_IDX_NS_DATA:  st_nxt.ns_data  = merge(st_r.ns_data, ACC_WDATA, wr_mask); // R6
        `SACC_IDX_MIX_PIN:  st_nxt.mix_pin  = merge(st_r.mix_pin, ACC_WDATA, wr_mask); // R11
        `SACC_IDX_NVM_CTRL: st_nxt.nvm_ctrl = merge(st_r.nvm_ctrl, ACC_WDATA, wr_mask); // R12
        default: begin
        end
      endcase
    end
    // Set wins over a clear arriving in the same cycle
    if (attr_hit && st_r.inten) begin
      st_nxt.flag = 1'b1; // R3
    end
    st_nxt.irq = st_r.flag && st_r.inten; // R2
  end

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign ACC_RDATA  = st_r.rdata;
  assign ACC_DONE   = st_r.done;
  assign ACC_DENIED = st_r.denied;
  assign ATTR_OUT   = st_r.attr;
  assign CHK_IRQ    = st_r.irq;

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RESET_N);

  sequence s_attr_change;
    ACC_VALID && ACC_WRITE && ACC_SECURE && ACC_IDX == `SACC_IDX_ATTR && st_r.inten
      && ACC_WDATA != st_r.chk;
  endsequence

  sequence s_irq_rise;
    ##1 st_r.flag ##1 CHK_IRQ;
  endsequence

  sequence s_irq_fall;
    ##1 !st_r.flag ##1 !CHK_IRQ;
  endsequence

  a_attr_ns_read: assert property ( // R1
    ACC_VALID && !ACC_WRITE && !ACC_SECURE && ACC_IDX == `SACC_IDX_ATTR
      |=> ACC_RDATA == $past(st_r.attr) && !ACC_DENIED)
    else $error("attribution not readable from non-secure alias");

  a_chk_irq_raise: assert property ( // R3
    s_attr_change |-> s_irq_rise)
    else $error("attribution change did not raise check interrupt");

  a_irq_needs_en: assert property ( // R2
    CHK_IRQ |-> $past(st_r.flag) && $past(st_r.inten))
    else $error("check interrupt without armed flag");

  a_ns_both_alias: assert property ( // R6
    ACC_VALID && ACC_WRITE && ACC_IDX == `SACC_IDX_NS_DATA
      |=> st_r.ns_data == $past(ACC_WDATA) && !ACC_DENIED)
    else $error("non-secure class register not writable");

  a_sec_hidden: assert property ( // R7
    ACC_VALID && !ACC_SECURE && ACC_IDX == `SACC_IDX_SEC_CFG
      |=> ACC_DENIED && ACC_RDATA == `SACC_RST_WORD && $stable(st_r.sec_cfg))
    else $error("secure register reached through non-secure alias");

  a_wsec_sec_write: assert property ( // R8
    ACC_VALID && ACC_WRITE && ACC_SECURE && ACC_IDX == `SACC_IDX_ATTR
      |=> st_r.attr == $past(ACC_WDATA))
    else $error("secure write to attribution lost");

  a_wsec_ns_block: assert property ( // R9
    ACC_VALID && ACC_WRITE && !ACC_SECURE && ACC_IDX == `SACC_IDX_ATTR
      |=> $stable(st_r.attr) && ACC_DENIED)
    else $error("non-secure write changed write-secure register");

  a_mix_per_bit: assert property ( // R11
    ACC_VALID && ACC_WRITE && !ACC_SECURE && ACC_IDX == `SACC_IDX_MIX_PIN
      |=> st_r.mix_pin == (($past(st_r.mix_pin) & ~$past(st_r.attr)) | ($past(ACC_WDATA) & $past(st_r.attr))))
    else $error("mixed register not enforced per bit");

  a_nvm_ns_write: assert property ( // R12
    ACC_VALID && ACC_WRITE && !ACC_SECURE && ACC_IDX == `SACC_IDX_NVM_CTRL
      |=> st_r.nvm_ctrl == ($past(st_r.attr[`SACC_NVM_NSWR_BIT]) ? $past(ACC_WDATA) : $past(st_r.nvm_ctrl)))
    else $error("memory controller write authorisation wrong");

  a_forbid_zero: assert property ( // R13
    ACC_VALID && !ACC_WRITE && !ACC_SECURE && ACC_IDX == `SACC_IDX_MIX_PIN
      |=> ACC_DONE && ACC_RDATA == ($past(st_r.mix_pin) & $past(st_r.attr)))
    else $error("forbidden bits not read as zero");

  // Idle cycles must not show a stale word on the read bus
  a_idle_quiet: assert property ( // R13
    !ACC_VALID
      |=> !ACC_DONE && !ACC_DENIED && ACC_RDATA == `SACC_RST_WORD)
    else $error("read bus not quiet while idle");

  a_answer_next: assert property ( // R13
    ACC_VALID |=> ACC_DONE)
    else $error("access not answered in the next cycle");

  a_ns_read_both: assert property ( // R6
    ACC_VALID && !ACC_WRITE && ACC_IDX == `SACC_IDX_NS_DATA
      |=> ACC_RDATA == $past(st_r.ns_data) && !ACC_DENIED)
    else $error("non-secure class register not readable");

  a_sec_full_read: assert property ( // R7
    ACC_VALID && !ACC_WRITE && ACC_SECURE && ACC_IDX == `SACC_IDX_SEC_CFG
      |=> ACC_RDATA == $past(st_r.sec_cfg) && !ACC_DENIED)
    else $error("secure register not readable from secure alias");

  a_sec_full_write: assert property ( // R7
    ACC_VALID && ACC_WRITE && ACC_SECURE && ACC_IDX == `SACC_IDX_SEC_CFG
      |=> st_r.sec_cfg == $past(ACC_WDATA) && !ACC_DENIED)
    else $error("secure register not writable from secure alias");

  a_wsec_sec_read: assert property ( // R8
    ACC_VALID && !ACC_WRITE && ACC_SECURE && ACC_IDX == `SACC_IDX_ATTR
      |=> ACC_RDATA == $past(st_r.attr) && !ACC_DENIED)
    else $error("attribution not readable from secure alias");

  a_mix_sec_write: assert property ( // R10
    ACC_VALID && ACC_WRITE && ACC_SECURE && ACC_IDX == `SACC_IDX_MIX_PIN
      |=> st_r.mix_pin == $past(ACC_WDATA) && !ACC_DENIED)
    else $error("mixed register not writable from secure alias");

  a_mix_all_denied: assert property ( // R11
    ACC_VALID && !ACC_SECURE && ACC_IDX == `SACC_IDX_MIX_PIN && st_r.attr == `SACC_RST_WORD
      |=> ACC_DENIED && ACC_RDATA == `SACC_RST_WORD)
    else $error("mixed register with no granted bit not denied");

  a_nvm_ns_read: assert property ( // R12
    ACC_VALID && !ACC_WRITE && !ACC_SECURE && ACC_IDX == `SACC_IDX_NVM_CTRL
      |=> ACC_RDATA == $past(st_r.nvm_ctrl) && !ACC_DENIED)
    else $error("memory controller not readable from non-secure alias");

  a_nvm_sec_write: assert property ( // R12
    ACC_VALID && ACC_WRITE && ACC_SECURE && ACC_IDX == `SACC_IDX_NVM_CTRL
      |=> st_r.nvm_ctrl == $past(ACC_WDATA))
    else $error("secure write to memory controller lost");

  a_nvm_ns_blocked: assert property ( // R12
    ACC_VALID && ACC_WRITE && !ACC_SECURE && ACC_IDX == `SACC_IDX_NVM_CTRL && !st_r.attr[`SACC_NVM_NSWR_BIT]
      |=> ACC_DENIED && $stable(st_r.nvm_ctrl))
    else $error("unauthorised memory controller write not blocked");

  a_chk_load: assert property ( // R2
    ACC_VALID && ACC_WRITE && ACC_IDX == `SACC_IDX_CHK
      |=> st_r.chk == $past(ACC_WDATA) && !ACC_DENIED)
    else $error("check register not loaded");

  a_inten_load: assert property ( // R2
    ACC_VALID && ACC_WRITE && ACC_IDX == `SACC_IDX_INTEN
      |=> st_r.inten == $past(ACC_WDATA[`SACC_CHK_EN_BIT]))
    else $error("check interrupt enable not loaded");

  a_flag_clear: assert property ( // R2
    ACC_VALID && ACC_WRITE && ACC_IDX == `SACC_IDX_INTFLAG && ACC_WDATA[`SACC_CHK_FLAG_BIT] |-> s_irq_fall)
    else $error("check flag or interrupt not cleared");

  a_flag_holds: assert property ( // R3
    st_r.flag && !(ACC_VALID && ACC_WRITE && ACC_IDX == `SACC_IDX_INTFLAG && ACC_WDATA[`SACC_CHK_FLAG_BIT])
      |=> st_r.flag)
    else $error("check flag dropped without a clear");

  // Only a secure attribution write may raise the flag
  a_flag_quiet: assert property ( // R3
    !st_r.flag && !(ACC_VALID && ACC_WRITE && ACC_SECURE && ACC_IDX == `SACC_IDX_ATTR)
      |=> !st_r.flag)
    else $error("check flag raised without attribution write");

  a_same_no_flag: assert property ( // R3
    ACC_VALID && ACC_WRITE && ACC_SECURE && ACC_IDX == `SACC_IDX_ATTR && ACC_WDATA == st_r.chk && !st_r.flag
      |=> !st_r.flag)
    else $error("unchanged attribution raised check flag");

  a_disarmed_quiet: assert property ( // R3
    !st_r.inten && !st_r.flag |=> !st_r.flag)
    else $error("check flag raised while disarmed");

  a_irq_off: assert property ( // R2
    !st_r.inten |=> !CHK_IRQ)
    else $error("check interrupt while disabled");

  a_read_keeps: assert property ( // R13
    ACC_VALID && !ACC_WRITE
      |=> $stable(st_r.attr) && $stable(st_r.mix_pin) && $stable(st_r.nvm_ctrl) && $stable(st_r.chk))
    else $error("read changed register contents");

endmodule : sacc_check

/* File: tb/sacc_master.sv */
// Model of the secure and non-secure bus masters reaching the register aliases
`timescale 1ns/1ps
`include "sacc_map.svh"

module sacc_master (
  input  wire logic                CLK_SYS,
  input  wire logic                ACC_DONE,
  input  wire logic                ACC_DENIED,
  input  wire logic [`SACC_DW-1:0] ACC_RDATA,
  output logic                     ACC_VALID,
  output logic                     ACC_SECURE,
  output logic                     ACC_WRITE,
  output logic      [`SACC_AW-1:0] ACC_IDX,
  output logic      [`SACC_DW-1:0] ACC_WDATA
);
  initial begin
    ACC_VALID  = 1'b0;
    ACC_SECURE = 1'b0;
    ACC_WRITE  = 1'b0;
    ACC_IDX    = 3'h0;
    ACC_WDATA  = 32'h0000_0000;
  end

  task acc(input logic s, input logic w, input logic [2:0] i, input logic [31:0] d,
           output logic [31:0] rd, output logic dn);
    int n;
    @(posedge CLK_SYS);
    #1;
    ACC_SECURE = s;
    ACC_WRITE  = w;
    ACC_IDX    = i;
    ACC_WDATA  = d;
    ACC_VALID  = 1'b1;
    @(posedge CLK_SYS);
    #1;
    ACC_VALID = 1'b0;
    // Released data toggles so a stale word is never mistaken for a held one
    ACC_WDATA = ~ACC_WDATA;
    n = 0;
    while (ACC_DONE !== 1'b1 && n < 4) begin
      @(posedge CLK_SYS);
      #1;
      n++;
    end
    rd = ACC_RDATA;
    dn = ACC_DENIED;
  endtask : acc

  // Copy attribution into the monitor first, enable only afterwards
  task arm;
    logic [31:0] v;
    logic        dn;
    acc(1'b0, 1'b0, `SACC_IDX_ATTR, 32'h0, v, dn);
    acc(1'b0, 1'b1, `SACC_IDX_CHK, v, v, dn);
    acc(1'b0, 1'b1, `SACC_IDX_INTEN, 32'h0000_0001, v, dn);
  endtask : arm

  task handler;
    logic [31:0] v;
    logic        dn;
    acc(1'b0, 1'b0, `SACC_IDX_ATTR, 32'h0, v, dn);
    acc(1'b0, 1'b1, `SACC_IDX_CHK, v, v, dn);
    acc(1'b0, 1'b1, `SACC_IDX_INTFLAG, 32'h0000_0001, v, dn);
  endtask : handler
endmodule : sacc_master

/* File: tb/security_attribution_access_check_tb.sv */
// Self-checking bench for the attribution checker
`timescale 1ns/1ps
`include "sacc_map.svh"
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin num_errors++; \
  $display("mismatch %s expected %h seen %h", nm, e, g); end end

module security_attribution_access_check_tb;
  logic        clk_sys = 1'b0;
  logic        reset_n = 1'b0;
  logic        acc_valid, acc_secure, acc_write, acc_done, acc_denied, chk_irq, dn;
  logic [2:0]  acc_idx;
  logic [31:0] acc_wdata, acc_rdata, attr_out, rd;
  int          num_errors = 0;
  int          samples_checked = 0;

  always #2.5 clk_sys = ~clk_sys;

  sacc_check dut_u (.CLK_SYS(clk_sys), .RESET_N(reset_n), .ACC_VALID(acc_valid), .ACC_SECURE(acc_secure),
    .ACC_WRITE(acc_write), .ACC_IDX(acc_idx), .ACC_WDATA(acc_wdata), .ACC_RDATA(acc_rdata),
    .ACC_DONE(acc_done), .ACC_DENIED(acc_denied), .ATTR_OUT(attr_out), .CHK_IRQ(chk_irq));
  sacc_master m (.CLK_SYS(clk_sys), .ACC_DONE(acc_done), .ACC_DENIED(acc_denied), .ACC_RDATA(acc_rdata),
    .ACC_VALID(acc_valid), .ACC_SECURE(acc_secure), .ACC_WRITE(acc_write), .ACC_IDX(acc_idx),
    .ACC_WDATA(acc_wdata));

  task tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : tally_and_finish

  task t_wsec;
    m.acc(1'b0, 1'b0, `SACC_IDX_ATTR, 32'h0, rd, dn);
    `CHK("attr_reset", 32'h0000_0000, rd)
    `CHK("done_pulse", 1'b1, acc_done)
    m.acc(1'b1, 1'b1, `SACC_IDX_ATTR, 32'h8000_00F0, rd, dn);
    m.acc(1'b0, 1'b0, `SACC_IDX_ATTR, 32'h0, rd, dn);
    `CHK("attr_ns_read", 32'h8000_00F0, rd)
    m.acc(1'b0, 1'b1, `SACC_IDX_ATTR, 32'h0, rd, dn);
    `CHK("attr_ns_wr_denied", 1'b1, dn)
    m.acc(1'b1, 1'b0, `SACC_IDX_ATTR, 32'h0, rd, dn);
    `CHK("attr_sec_read", 32'h8000_00F0, rd)
    `CHK("attr_out", 32'h8000_00F0, attr_out)
    $display("test wsec done");
  endtask : t_wsec

  task t_sec;
    m.acc(1'b1, 1'b1, `SACC_IDX_SEC_CFG, 32'hA5A5_5A5A, rd, dn);
    m.acc(1'b0, 1'b0, `SACC_IDX_SEC_CFG, 32'h0, rd, dn);
    `CHK("sec_ns_read", 32'h0000_0000, rd)
    `CHK("sec_ns_denied", 1'b1, dn)
    m.acc(1'b0, 1'b1, `SACC_IDX_SEC_CFG, 32'h0, rd, dn);
    m.acc(1'b1, 1'b0, `SACC_IDX_SEC_CFG, 32'h0, rd, dn);
    `CHK("sec_kept", 32'hA5A5_5A5A, rd)
    $display("test sec done");
  endtask : t_sec

  task t_ns;
    m.acc(1'b0, 1'b1, `SACC_IDX_NS_DATA, 32'h1234_5678, rd, dn);
    m.acc(1'b1, 1'b0, `SACC_IDX_NS_DATA, 32'h0, rd, dn);
    `CHK("ns_sec_read", 32'h1234_5678, rd)
    m.acc(1'b1, 1'b1, `SACC_IDX_NS_DATA, 32'hCAFE_0001, rd, dn);
    m.acc(1'b0, 1'b0, `SACC_IDX_NS_DATA, 32'h0, rd, dn);
    `CHK("ns_ns_read", 32'hCAFE_0001, rd)
    $display("test ns done");
  endtask : t_ns

  task t_mix;
    m.acc(1'b1, 1'b1, `SACC_IDX_MIX_PIN, 32'h0, rd, dn);
    m.acc(1'b0, 1'b1, `SACC_IDX_MIX_PIN, 32'hFFFF_FFFF, rd, dn);
    `CHK("mix_partial_ok", 1'b0, dn)
    m.acc(1'b1, 1'b0, `SACC_IDX_MIX_PIN, 32'h0, rd, dn);
    `CHK("mix_ns_write_bits", 32'h8000_00F0, rd)
    m.acc(1'b1, 1'b1, `SACC_IDX_MIX_PIN, 32'hFFFF_FFFF, rd, dn);
    m.acc(1'b0, 1'b0, `SACC_IDX_MIX_PIN, 32'h0, rd, dn);
    `CHK("mix_ns_read_bits", 32'h8000_00F0, rd)
    $display("test mix done");
  endtask : t_mix

  task t_nvm;
    m.acc(1'b0, 1'b1, `SACC_IDX_NVM_CTRL, 32'h0000_0011, rd, dn);
    m.acc(1'b1, 1'b0, `SACC_IDX_NVM_CTRL, 32'h0, rd, dn);
    `CHK("nvm_auth_write", 32'h0000_0011, rd)
    m.acc(1'b1, 1'b1, `SACC_IDX_ATTR, 32'h0000_00F0, rd, dn);
    m.acc(1'b0, 1'b1, `SACC_IDX_NVM_CTRL, 32'h0000_0022, rd, dn);
    `CHK("nvm_unauth_denied", 1'b1, dn)
    m.acc(1'b0, 1'b0, `SACC_IDX_NVM_CTRL, 32'h0, rd, dn);
    `CHK("nvm_ns_read", 32'h0000_0011, rd)
    $display("test nvm done");
  endtask : t_nvm

  task t_irq;
    m.arm();
    `CHK("irq_armed_quiet", 1'b0, chk_irq)
    m.acc(1'b1, 1'b1, `SACC_IDX_ATTR, 32'h0000_0F00, rd, dn);
    repeat (3) @(posedge clk_sys);
    #1;
    `CHK("irq_on_change", 1'b1, chk_irq)
    m.handler();
    repeat (3) @(posedge clk_sys);
    #1;
    `CHK("irq_cleared", 1'b0, chk_irq)
    // Same value as the monitor copy is not a change
    m.acc(1'b1, 1'b1, `SACC_IDX_ATTR, 32'h0000_0F00, rd, dn);
    repeat (3) @(posedge clk_sys);
    #1;
    `CHK("irq_same_value", 1'b0, chk_irq)
    $display("test irq done");
  endtask : t_irq

  task t_reset;
    @(posedge clk_sys);
    #1;
    reset_n = 1'b0;
    @(posedge clk_sys);
    #1;
    `CHK("rst_attr_out", 32'h0000_0000, attr_out)
    `CHK("rst_irq", 1'b0, chk_irq)
    reset_n = 1'b1;
    m.acc(1'b0, 1'b0, `SACC_IDX_INTEN, 32'h0, rd, dn);
    `CHK("rst_inten", 32'h0000_0000, rd)
    m.acc(1'b0, 1'b0, `SACC_IDX_MIX_PIN, 32'h0, rd, dn);
    `CHK("rst_mix_denied", 1'b1, dn)
    `CHK("rst_mix_zero", 32'h0000_0000, rd)
    $display("test reset done");
  endtask : t_reset

  initial begin
    #20000;
    num_errors++;
    tally_and_finish();
  end

  initial begin
    repeat (12) @(posedge clk_sys);
    #1;
    reset_n = 1'b1;
    t_wsec();
    t_sec();
    t_ns();
    t_mix();
    t_nvm();
    t_irq();
    t_reset();
    tally_and_finish();
  end
endmodule : security_attribution_access_check_tb
